// file: core/dlw_defs.vh
`ifndef DLW_DEFS_VH
`define DLW_DEFS_VH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DLW_NLINES 160
`define DLW_NPORTS 20
`define DLW_NWORDS 5
`define DLW_NTRIG 8
`define DLW_NSYNC 178
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DLW_A_OUT 8'h00
`define DLW_A_OEN 8'h20
`define DLW_A_IN 8'h40
`define DLW_A_LINE 8'h60
`define DLW_A_ARB 8'h64
`define DLW_A_TRIG 8'h68
`define DLW_A_TIN 8'h6C
`define DLW_A_WCTL 8'h70
`define DLW_A_WTMO 8'h74
`define DLW_A_ISTAT 8'h78
`define DLW_A_IMASK 8'h7C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DLW_LINE_DV 8
`define DLW_LINE_EV 9
`define DLW_LINE_WD 16
`define DLW_LINE_WE 17
`define DLW_TIN_CLK 8
`define DLW_TIN_SLOT 9
`define DLW_WCTL_MODE 8
`define DLW_WCTL_BUSY 16
`define DLW_WCTL_HIT 17
`define DLW_WCTL_TMO 18
`define DLW_WCTL_GO 31
`define DLW_IRQ_HIT 0
`define DLW_IRQ_TMO 1
// ----------------------------------------------------------------
// wait modes and reset values
// ----------------------------------------------------------------
`define DLW_M_ANY 3'h0
`define DLW_M_FALL 3'h1
`define DLW_M_RISE 3'h2
`define DLW_M_HIGH 3'h3
`define DLW_M_LOW 3'h4
`define DLW_RST_TMO 32'hFFFFFFFF
`define DLW_RST_ZERO 32'h00000000
`define DLW_STRAP_AT 2'h2
`endif

// file: core/dlw_dio_unit.v
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "dlw_defs.vh"
module dlw_dio_unit (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // bidirectional lines
  input wire [159:0] bidir_line_i,
  output wire [159:0] bidir_line_o,
  output wire [159:0] bidir_line_oe,
  // local bus left and star trigger channels
  input wire [7:0] lbl_i,
  output wire [7:0] lbl_o,
  output wire [7:0] lbl_oe,
  input wire [7:0] star_i,
  output wire [7:0] star_o,
  output wire [7:0] star_oe,
  // chassis reference clock and slot strap
  input wire ref_clk_i,
  input wire slot_two_i,
  // direct user-logic port accessor
  input wire usr_wr,
  input wire [4:0] usr_port,
  input wire [7:0] usr_data,
  input wire [7:0] usr_en,
  output wire [7:0] usr_rd,
  // interrupt
  output wire irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [159:0] out_q;
  reg [159:0] out_d;
  reg [159:0] oen_q;
  reg [159:0] oen_d;
  reg [19:0] arb_q;
  reg [7:0] trd_q;
  reg [7:0] tre_q;
  reg [7:0] wsel_q;
  reg [2:0] wmode_q;
  reg [31:0] wtmo_q;
  reg [1:0] istat_q;
  reg [1:0] istat_d;
  reg [1:0] imask_q;
  reg slot_q;
  reg [1:0] strap_cnt_q;
  reg [31:0] prdata_q;
  reg [31:0] rd_d;
  reg [7:0] usr_rd_q;
  reg [4:0] pi;
  reg apb_tp;
  reg usr_tp;
  integer p;

  wire [177:0] sync_q;
  wire [159:0] line_s;
  wire [7:0] lbl_s;
  wire [7:0] star_s;
  wire ref_s;
  wire slot_s;
  wire [7:0] trig_s;
  wire w_busy;
  wire w_done;
  wire w_hit;
  wire w_tmo;
  wire w_line;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dlw_sync #(
    .W(`DLW_NSYNC)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .d({slot_two_i, ref_clk_i, star_i, lbl_i, bidir_line_i}),
    .q(sync_q)
  );

  assign line_s = sync_q[159:0];
  assign lbl_s = sync_q[167:160];
  assign star_s = sync_q[175:168];
  assign ref_s = sync_q[176];
  assign slot_s = sync_q[177];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // word banks of five words each, 32 lines per word
  function bank_hit;
    input [7:0] a;
    input [7:0] base;
    begin
      bank_hit = (a[7:5] == base[7:5]) && (a[4:2] < 3'h5) && (a[1:0] == 2'h0);
    end
  endfunction

  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit_out = bank_hit(paddr, `DLW_A_OUT);
  wire hit_oen = bank_hit(paddr, `DLW_A_OEN);
  wire hit_in = bank_hit(paddr, `DLW_A_IN);
  wire mapped = hit_out | hit_oen | hit_in |
                (paddr == `DLW_A_LINE) | (paddr == `DLW_A_ARB) |
                (paddr == `DLW_A_TRIG) | (paddr == `DLW_A_TIN) |
                (paddr == `DLW_A_WCTL) | (paddr == `DLW_A_WTMO) |
                (paddr == `DLW_A_ISTAT) | (paddr == `DLW_A_IMASK);
  wire wr = acc & pwrite & ce;
  wire wr_out = wr & hit_out;
  wire wr_oen = wr & hit_oen;
  wire wr_line = wr & (paddr == `DLW_A_LINE) & (pwdata[7:0] < 8'hA0);
  wire [7:0] lidx = pwdata[7:0];
  wire [2:0] wsel = paddr[4:2];
  // a start while the engine is busy is dropped
  wire w_start = wr & (paddr == `DLW_A_WCTL) & pwdata[`DLW_WCTL_GO] & ~w_busy;

  // zero-wait slave: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // output data and enable with per-port arbitration
  // ----------------------------------------------------------------
  // apb and user port may hit the same port in one cycle; arb bit picks
  always @* begin
    out_d = out_q;
    oen_d = oen_q;
    pi = 5'h00;
    apb_tp = 1'b0;
    usr_tp = 1'b0;
    for (p = 0; p < `DLW_NPORTS; p = p + 1) begin
      pi = p[4:0];
      apb_tp = ((wr_out | wr_oen) && wsel == pi[4:2]) ||
               (wr_line && lidx[7:3] == pi);
      usr_tp = usr_wr && ce && usr_port == pi;
      if (apb_tp && !(usr_tp && arb_q[p])) begin
        if (wr_out && wsel == pi[4:2])
          out_d[pi*8 +: 8] = pwdata[pi[1:0]*8 +: 8];
        if (wr_oen && wsel == pi[4:2])
          oen_d[pi*8 +: 8] = pwdata[pi[1:0]*8 +: 8];
        if (wr_line && lidx[7:3] == pi && pwdata[`DLW_LINE_WD])
          out_d[lidx] = pwdata[`DLW_LINE_DV];
        if (wr_line && lidx[7:3] == pi && pwdata[`DLW_LINE_WE])
          oen_d[lidx] = pwdata[`DLW_LINE_EV];
      end
      if (usr_tp && !(apb_tp && !arb_q[p])) begin
        out_d[pi*8 +: 8] = usr_data;
        oen_d[pi*8 +: 8] = usr_en;
      end
    end
  end

  // the line drivers themselves; data and enable never coupled
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_q <= 160'h0;
      oen_q <= 160'h0;
    end else if (ce) begin
      out_q <= out_d;
      oen_q <= oen_d;
    end
  end

  assign bidir_line_o = out_q;
  assign bidir_line_oe = oen_q;

  // user port read-back, one port byte per cycle
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      usr_rd_q <= 8'h00;
    end else if (ce) begin
      if (usr_port < 5'h14)
        usr_rd_q <= line_s[usr_port*8 +: 8];
      else
        usr_rd_q <= 8'h00;
    end
  end

  assign usr_rd = usr_rd_q;

  // ----------------------------------------------------------------
  // slot strap and trigger routing
  // ----------------------------------------------------------------
  // strap caught once the synchroniser has refilled after release; the
  // sync stages are cleared by reset, so an earlier sample would read zero
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_q <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else if (ce && strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `DLW_STRAP_AT)
        slot_q <= slot_s;
    end
  end

  // in slot two the left bus drive moves onto the star pins
  assign lbl_o = slot_q ? 8'h00 : trd_q;
  assign lbl_oe = slot_q ? 8'h00 : tre_q;
  assign star_o = slot_q ? trd_q : 8'h00;
  assign star_oe = slot_q ? tre_q : 8'h00;
  assign trig_s = slot_q ? star_s : lbl_s;

  // ----------------------------------------------------------------
  // wait engine
  // ----------------------------------------------------------------
  // select 0..159 lines, 160..167 trigger channels, above: ref clock
  function pick;
    input [7:0] s;
    input [159:0] ln;
    input [7:0] tr;
    input ck;
    begin
      if (s < 8'hA0)
        pick = ln[s];
      else if (s < 8'hA8)
        pick = tr[s[2:0]];
      else
        pick = ck;
    end
  endfunction

  // the start cycle must see the select and mode being written, not the old ones
  assign w_line = pick(w_start ? pwdata[7:0] : wsel_q, line_s, trig_s, ref_s);

  dlw_wait u_wait (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .start(w_start),
    .mode(w_start ? pwdata[`DLW_WCTL_MODE +: 3] : wmode_q),
    .tmo(wtmo_q),
    .line(w_line),
    .busy(w_busy),
    .done(w_done),
    .hit(w_hit),
    .timed_out(w_tmo)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // wait settings are locked while the engine runs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arb_q <= 20'h00000;
      trd_q <= 8'h00;
      tre_q <= 8'h00;
      wsel_q <= 8'h00;
      wmode_q <= `DLW_M_ANY;
      wtmo_q <= `DLW_RST_TMO;
      imask_q <= 2'h0;
    end else if (wr) begin
      if (paddr == `DLW_A_ARB)
        arb_q <= pwdata[19:0];
      if (paddr == `DLW_A_TRIG) begin
        trd_q <= pwdata[7:0];
        tre_q <= pwdata[15:8];
      end
      if (paddr == `DLW_A_WCTL && !w_busy) begin
        wsel_q <= pwdata[7:0];
        wmode_q <= pwdata[`DLW_WCTL_MODE +: 3];
      end
      if (paddr == `DLW_A_WTMO && !w_busy)
        wtmo_q <= pwdata;
      if (paddr == `DLW_A_IMASK)
        imask_q <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // write-one-to-clear; a new event in the clearing cycle still sets
  always @* begin
    istat_d = istat_q;
    if (wr && paddr == `DLW_A_ISTAT)
      istat_d = istat_q & ~pwdata[1:0];
    if (w_done && w_hit)
      istat_d[`DLW_IRQ_HIT] = 1'b1;
    if (w_done && w_tmo)
      istat_d[`DLW_IRQ_TMO] = 1'b1;
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      istat_q <= 2'h0;
    else if (ce)
      istat_q <= istat_d;
  end

  assign irq = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unused bits and unmapped addresses read zero
  always @* begin
    rd_d = `DLW_RST_ZERO;
    if (hit_out)
      rd_d = out_q[paddr[4:2]*32 +: 32];
    else if (hit_oen)
      rd_d = oen_q[paddr[4:2]*32 +: 32];
    else if (hit_in)
      rd_d = line_s[paddr[4:2]*32 +: 32];
    else begin
      case (paddr)
        `DLW_A_ARB: rd_d[19:0] = arb_q;
        `DLW_A_TRIG: rd_d[15:0] = {tre_q, trd_q};
        `DLW_A_TIN: begin
          rd_d[7:0] = trig_s;
          rd_d[`DLW_TIN_CLK] = ref_s;
          rd_d[`DLW_TIN_SLOT] = slot_q;
        end
        `DLW_A_WCTL: begin
          rd_d[7:0] = wsel_q;
          rd_d[`DLW_WCTL_MODE +: 3] = wmode_q;
          rd_d[`DLW_WCTL_BUSY] = w_busy;
          rd_d[`DLW_WCTL_HIT] = w_hit;
          rd_d[`DLW_WCTL_TMO] = w_tmo;
        end
        `DLW_A_WTMO: rd_d = wtmo_q;
        `DLW_A_ISTAT: rd_d[1:0] = istat_q;
        `DLW_A_IMASK: rd_d[1:0] = imask_q;
        default: rd_d = `DLW_RST_ZERO;
      endcase
    end
  end

  // read data registered in setup and held through the access cycle
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      prdata_q <= `DLW_RST_ZERO;
    else if (ce && setup)
      prdata_q <= rd_d;
  end

  // the reference clock has no drive path at all: input only
  // (no output or enable exists for it anywhere in this unit)
endmodule // dlw_dio_unit

// file: core/dlw_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for pins from outside the clock domain
module dlw_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire ce,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage is read only by the second
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // dlw_sync

// file: core/dlw_wait.v
`timescale 1ns/10ps
`include "dlw_defs.vh"
// edge or level wait engine with signed tick timeout
module dlw_wait (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire ce,
  // request
  input wire start,
  input wire [2:0] mode,
  input wire [31:0] tmo,
  input wire line,
  // result
  output wire busy,
  output wire done,
  output wire hit,
  output wire timed_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] st_q;
  reg prev_q;
  reg inf_q;
  reg [30:0] cnt_q;
  reg done_q;
  reg hit_q;
  reg tmo_q;

  // condition test shared by the start cycle and the run state
  function met;
    input [2:0] m;
    input p;
    input c;
    begin
      case (m)
        `DLW_M_ANY: met = p ^ c;
        `DLW_M_FALL: met = p & ~c;
        `DLW_M_RISE: met = ~p & c;
        `DLW_M_HIGH: met = c;
        `DLW_M_LOW: met = ~c;
        default: met = 1'b0;
      endcase
    end
  endfunction

  // a level already met answers at once; edges need one compare first
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      prev_q <= 1'b0;
      inf_q <= 1'b0;
      cnt_q <= 31'h00000000;
      done_q <= 1'b0;
      hit_q <= 1'b0;
      tmo_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      prev_q <= line;
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            hit_q <= 1'b0;
            tmo_q <= 1'b0;
            inf_q <= tmo[31];
            cnt_q <= tmo[30:0];
            if (tmo == 32'h00000000) begin
              done_q <= 1'b1;
              tmo_q <= 1'b1;
            end else if ((mode == `DLW_M_HIGH || mode == `DLW_M_LOW) &&
                         met(mode, line, line)) begin
              done_q <= 1'b1;
              hit_q <= 1'b1;
            end else begin
              st_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (met(mode, prev_q, line)) begin
            done_q <= 1'b1;
            hit_q <= 1'b1;
            st_q <= ST_IDLE;
          end else if (!inf_q && cnt_q == 31'h00000001) begin
            done_q <= 1'b1;
            tmo_q <= 1'b1;
            st_q <= ST_IDLE;
          end else if (!inf_q) begin
            cnt_q <= cnt_q - 31'h00000001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign busy = st_q[1];
  assign done = done_q;
  assign hit = hit_q;
  assign timed_out = tmo_q;
endmodule // dlw_wait

// file: verification/dlw_dio_unit_checker.sv
`timescale 1ns/10ps
// --------
// port checks of the digital i/o unit
// --------
module dlw_dio_unit_checker (
  // clock and reset
  input wire clock,
  input wire nrst,
  input wire ce,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins and user port
  input wire [159:0] bidir_line_o,
  input wire [159:0] bidir_line_oe,
  input wire [7:0] lbl_oe,
  input wire [7:0] star_oe,
  input wire slot_two_i,
  input wire usr_wr,
  input wire [4:0] usr_port,
  input wire [7:0] usr_data
);
  reg strap_q;
  reg [4:0] port_q;
  wire acc = psel && penable;
  wire wr = acc && pwrite && ce;
  wire hole = paddr[7] || paddr[1:0] != 2'h0 || (paddr[7:5] != 3'h3 && paddr[4:0] > 5'h10);
  wire [7:0] ubyte = bidir_line_o[{port_q, 3'h0} +: 8];
  // strap is only meaningful as held through reset; sampled on the clock
  // so that it cannot race the reset edge
  always @(posedge clock) begin
    if (!nrst)
      strap_q <= slot_two_i;
    port_q <= usr_port;
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_decode_a: assert property (pslverr == (acc && hole))
    else $error("pslverr wrong");
  hole_zero_a: assert property (acc && !pwrite && hole |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(psel && !penable && ce) |=> $stable(prdata))
    else $error("prdata moved");
  out_word_a: assert property (wr && paddr == 8'h00 && !usr_wr |=>
    bidir_line_o[31:0] == $past(pwdata))
    else $error("data word not applied");
  oen_word_a: assert property (wr && paddr == 8'h30 && !usr_wr |=>
    bidir_line_oe[159:128] == $past(pwdata))
    else $error("enable word not applied");
  usr_byte_a: assert property (usr_wr && ce && !wr |=> ubyte == $past(usr_data))
    else $error("user port byte not applied");
  ce_freeze_a: assert property (!ce |=> $stable(bidir_line_o) && $stable(bidir_line_oe))
    else $error("pins moved without clock enable");
  left_off_a: assert property (strap_q |-> lbl_oe == 8'h00)
    else $error("left bus driven in slot two");
  star_off_a: assert property (!strap_q |-> star_oe == 8'h00)
    else $error("star driven outside slot two");
endmodule // dlw_dio_unit_checker

bind dlw_dio_unit dlw_dio_unit_checker u_dlw_dio_unit_checker (.clock, .nrst, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bidir_line_o,
  .bidir_line_oe, .lbl_oe, .star_oe, .slot_two_i, .usr_wr, .usr_port, .usr_data);

// file: verification/dlw_pins_model.sv
`timescale 1ns/10ps
// --------
// far side of the unit: wired pins with pull-downs and the chassis reference
// --------
module dlw_pins_model (
  // device drivers
  input wire [159:0] line_o,
  input wire [159:0] line_oe,
  input wire [7:0] lb_o,
  input wire [7:0] lb_oe,
  input wire [7:0] st_o,
  input wire [7:0] st_oe,
  // far-side drive levels
  input wire [159:0] ext_d,
  // pin levels seen by the unit
  output wire [159:0] line_i,
  output wire [7:0] lb_i,
  output wire [7:0] st_i,
  output reg ref_clk
);
  // the unit's driver wins; an undriven trigger falls to its pull-down
  assign line_i = (line_o & line_oe) | (ext_d & ~line_oe);
  assign lb_i = lb_o & lb_oe;
  assign st_i = st_o & st_oe;
  // free-running chassis reference, never fed from the unit
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
endmodule // dlw_pins_model

// file: verification/tb.sv
`timescale 1ns/10ps
`include "dlw_defs.vh"
// --------
// self-checking bench of the digital i/o unit
// --------
module tb;
  reg clock, nrst, ce, psel, penable, pwrite, slot_two_i, usr_wr;
  reg [7:0] paddr, usr_data, usr_en;
  reg [4:0] usr_port;
  reg [31:0] pwdata, seed, d, e, x;
  reg [159:0] ext_d;
  reg [31:0] exp_q[$];
  reg [31:0] msk_q[$];
  wire [31:0] prdata;
  wire pready, pslverr, irq, ref_clk_i;
  wire [159:0] bidir_line_i, bidir_line_o, bidir_line_oe;
  wire [7:0] lbl_i, lbl_o, lbl_oe, star_i, star_o, star_oe, usr_rd;
  integer fail_count, checks_done, cycles, i;
  dlw_dio_unit u_dlw_dio_unit (.clock, .nrst, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bidir_line_i, .bidir_line_o, .bidir_line_oe,
    .lbl_i, .lbl_o, .lbl_oe, .star_i, .star_o, .star_oe, .ref_clk_i, .slot_two_i,
    .usr_wr, .usr_port, .usr_data, .usr_en, .usr_rd, .irq);
  dlw_pins_model u_dlw_pins_model (.line_o(bidir_line_o), .line_oe(bidir_line_oe),
    .lb_o(lbl_o), .lb_oe(lbl_oe), .st_o(star_o), .st_oe(star_oe), .ext_d,
    .line_i(bidir_line_i), .lb_i(lbl_i), .st_i(star_i), .ref_clk(ref_clk_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer; col raises the user strobe in the access phase
  task apb(input logic [7:0] a, input logic w, input logic [31:0] v, input logic col);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge clock);
    penable <= 1'b1;
    usr_wr <= col;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    usr_wr <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    apb(a, 1'b1, v, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back(v & m);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h00000000, 1'b0);
  endtask
  // one wait on line 0: level before start, level after, timeout, status bits
  task wt(input logic [2:0] m, input logic pre, post, input logic [31:0] t, input logic [2:0] st);
    ext_d[0] <= pre;
    wr(`DLW_A_WTMO, t);
    tick(3);
    wr(`DLW_A_WCTL, {1'b1, 20'h00000, m, 8'h00});
    tick(2);
    ext_d[0] <= post;
    tick(8);
    rd(`DLW_A_WCTL, {13'h0000, st, 16'h0000}, 32'h00070000);
  endtask
  // compare each completed read with the oldest note
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // cut a hang short
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      stop_test;
    end
  end
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, slot_two_i, usr_wr} = 6'h00;
    {paddr, usr_data, usr_en, usr_port, pwdata} = 61'h0;
    ce = 1'b1;
    ext_d = 160'h0;
    seed = 32'hAFF7;
    {fail_count, checks_done, cycles} = 96'h0;
    tick(6);
    nrst <= 1'b1;
    tick(1);
    rd(`DLW_A_WTMO, `DLW_RST_TMO, 32'hFFFFFFFF);
    rd(`DLW_A_IMASK, `DLW_RST_ZERO, 32'hFFFFFFFF);
    rd(8'h84, 32'h00000000, 32'hFFFFFFFF);
    for (i = 0; i < 5; i++) begin
      d = rnd();
      e = rnd();
      x = rnd();
      ext_d[32 * i +: 32] <= x;
      wr(8'(`DLW_A_OUT + 4 * i), d);
      wr(8'(`DLW_A_OEN + 4 * i), e);
      check("line data", bidir_line_o[32 * i +: 32], d);
      check("line enable", bidir_line_oe[32 * i +: 32], e);
      tick(3);
      rd(8'(`DLW_A_IN + 4 * i), (d & e) | (x & ~e), 32'hFFFFFFFF);
      rd(8'(`DLW_A_OUT + 4 * i), d, 32'hFFFFFFFF);
    end
    // user port writes on consecutive cycles
    usr_en <= 8'h0E;
    for (i = 0; i < 4; i++) begin
      usr_wr <= 1'b1;
      usr_port <= 5'(i);
      usr_data <= 8'h11 * 8'(i + 1);
      @(posedge clock);
    end
    usr_wr <= 1'b0;
    tick(4);
    check("port data", bidir_line_o[31:0], 32'h44332211);
    check("port enable", bidir_line_oe[31:0], 32'h0E0E0E0E);
    check("port read", {24'h0, usr_rd}, {24'h0, 8'h04 | (ext_d[31:24] & 8'hF1)});
    // same-cycle collisions, user then apb preferred on port 1
    wr(`DLW_A_ARB, 32'h00000002);
    usr_port <= 5'h01;
    usr_data <= 8'hC3;
    apb(`DLW_A_OUT, 1'b1, 32'h5A5A5A5A, 1'b1);
    check("user wins", bidir_line_o[31:0], 32'h5A5AC35A);
    wr(`DLW_A_ARB, 32'h00000000);
    apb(`DLW_A_OUT, 1'b1, 32'h96969696, 1'b1);
    check("apb wins", bidir_line_o[31:0], 32'h96969696);
    ce <= 1'b0;
    usr_wr <= 1'b1;
    @(posedge clock);
    usr_wr <= 1'b0;
    ce <= 1'b1;
    @(posedge clock);
    check("frozen", bidir_line_o[31:0], 32'h96969696);
    wr(`DLW_A_LINE, 32'h00030325);
    check("single line", {bidir_line_oe[37], bidir_line_o[37]}, 2'h3);
    wr(`DLW_A_OEN, 32'h00000000);
    wt(`DLW_M_ANY, 1'b0, 1'b1, `DLW_RST_TMO, 3'h2);
    wt(`DLW_M_ANY, 1'b1, 1'b0, 32'h00000014, 3'h2);
    wt(`DLW_M_FALL, 1'b1, 1'b0, 32'h0000000C, 3'h2);
    wt(`DLW_M_FALL, 1'b0, 1'b1, 32'h00000004, 3'h4);
    wt(`DLW_M_RISE, 1'b1, 1'b0, 32'h00000006, 3'h4);
    wt(`DLW_M_RISE, 1'b0, 1'b1, `DLW_RST_TMO, 3'h2);
    wt(`DLW_M_HIGH, 1'b1, 1'b1, 32'h00000000, 3'h4);
    wt(`DLW_M_HIGH, 1'b1, 1'b1, `DLW_RST_TMO, 3'h2);
    wt(`DLW_M_LOW, 1'b0, 1'b0, 32'h00000003, 3'h2);
    wt(`DLW_M_LOW, 1'b1, 1'b1, `DLW_RST_TMO, 3'h1);
    ext_d[0] <= 1'b0;
    tick(6);
    rd(`DLW_A_WCTL, 32'h00020000, 32'h00070000);
    // rising edge of the chassis reference seen through its read-only select
    wr(`DLW_A_WTMO, 32'h00000014);
    wr(`DLW_A_WCTL, 32'h800002A8);
    tick(15);
    rd(`DLW_A_WCTL, 32'h00020000, 32'h00070000);
    // events stay sticky; mask and clear the interrupt
    rd(`DLW_A_ISTAT, 32'h00000003, 32'h00000003);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`DLW_A_IMASK, 32'h00000001);
    tick(2);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(`DLW_A_ISTAT, 32'h00000001);
    tick(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(`DLW_A_ISTAT, 32'h00000002, 32'h00000003);
    // triggers on the left bus, then on star after a reset in slot two
    wr(`DLW_A_TRIG, 32'h0000FFA5);
    check("left bus", {16'h0, lbl_oe, lbl_o}, 32'h0000FFA5);
    tick(3);
    rd(`DLW_A_TIN, 32'h000000A5, 32'h000002FF);
    nrst <= 1'b0;
    slot_two_i <= 1'b1;
    tick(6);
    nrst <= 1'b1;
    tick(4);
    wr(`DLW_A_TRIG, 32'h0000FF3C);
    check("star bus", {8'h0, star_oe, star_o, lbl_oe}, 32'h00FF3C00);
    tick(3);
    rd(`DLW_A_TIN, 32'h0000023C, 32'h000002FF);
    tick(2);
    stop_test;
  end
endmodule // tb
